// ---- logic/clock_divide_power_control_regs.svh ----
// register offsets, field positions, reset values and timing counts
`ifndef CLOCK_DIVIDE_POWER_CONTROL_REGS_SVH
`define CLOCK_DIVIDE_POWER_CONTROL_REGS_SVH
`define MEM_MAP_OFS      8'hC2
`define PWR_MGMT_OFS     8'hC4
`define ACT_STATUS_OFS   8'hC5
`define TA_KEY_OFS       8'hC7
`define EVT_STATUS_OFS   8'hE0
`define EVT_MASK_OFS     8'hE1
`define WAIT_EN_BIT      7
`define CDIV_HI_BIT      7
`define CDIV_LO_BIT      6
`define SWB_BIT          5
`define XSEL_BIT         3
`define ALE_SUP_BIT      2
`define XDIS_BIT         1
`define XDATA_EN_BIT     0
`define PIP_BIT          7
`define HIP_BIT          6
`define LIP_BIT          5
`define CRYSTAL_WARM_STATUS_BIT         4
`define EVT_SWB_BIT      0
`define EVT_WARM_BIT     1
`define EVT_W            2
`define CDIV_RST         2'h1
`define CDIV_DIV4        2'h1
`define CDIV_DIV64       2'h2
`define CDIV_DIV1024     2'h3
`define CDIV_RSVD        2'h0
`define PER_DIV4         11'h004
`define PER_DIV64        11'h040
`define PER_DIV1024      11'h400
`define TA_KEY_FIRST     8'hAA
`define TA_KEY_SECOND    8'h55
`define TA_OPEN_MC       2'h3
`define WARM_CYCLES      11'h400
`define CRYSTAL_WARM_STATUS_RST         1'h1
`endif

// ---- logic/clock_divide_power_control_pkg.sv ----
// types shared by the clock divide and power control block
package clock_divide_power_control_pkg;
  typedef enum logic [1:0] {
    TA_IDLE,
    TA_HALF,
    TA_OPEN
  } ta_state_t;
endpackage

// ---- logic/clock_divide_power_control.sv ----
// clock divide, switchback, crystal, strobe and timed access control
// Functional notes
// R1: divide code 01 gives 4, 10 gives 64, 11 gives 1024 clocks per cycle.
// R2: software goes back to divide-by-4 between the 64 and 1024 settings.
// R3: recognized external interrupt with switchback forces divide code 01.
// R4: start bit with switchback forces divide-by-4 at the next instruction.
// R5: crystal disable stops the crystal; set only while running from RC.
// R6: clearing crystal disable restarts crystal; warm status sets when ready.
// R7: warm status clears on restart or disable, reads 1 after reset.
// R8: crystal select cannot be set while warm status is clear.
// R9: strobe suppress hides strobe on on-chip accesses, not external ones.
// R10: on-chip xdata enable maps the 1KB SRAM for external data moves.
// R11: wait enable samples port 4 bit 0 wait during data moves; protected.
// R12: in-service bits set on entry, cleared by the matching return.
// R13: port 1 transmit activity sets while sending, clears on its flag.
// R14: port 1 receive activity sets while receiving, clears on its flag.
// R15: port 0 transmit and receive activity behave the same way.
// R16: divide writes ignored while switchback is on and any activity set.
// R17: key AAH then 55H opens a three machine cycle protected window.
// R18: protected bits hold outside the window; wrong second key aborts.
// R19: window closes by itself after three cycles at the current rate.
//
// The plain strobed port was chosen for this implementation.
`timescale 1ns/1ps
`include "clock_divide_power_control_regs.svh"
module clock_divide_power_control (
  input  wire logic       mclk_in,
  input  wire logic       arst_n_in,
  input  wire logic [7:0] addr_in,
  input  wire logic [7:0] wdata_in,
  input  wire logic       wr_in,
  input  wire logic       rd_in,
  output logic      [7:0] rdata_out,
  input  wire logic       ext_int_vector_in,
  input  wire logic       instr_start_in,
  input  wire logic       pd_exit_in,
  input  wire logic       pf_enter_in,
  input  wire logic       hi_enter_in,
  input  wire logic       lo_enter_in,
  input  wire logic       interrupt_return_in,
  input  wire logic       port0_tx_start_in,
  input  wire logic       port0_rx_start_in,
  input  wire logic       port0_tx_flag_in,
  input  wire logic       port0_rx_flag_in,
  input  wire logic       port1_tx_start_in,
  input  wire logic       port1_rx_start_in,
  input  wire logic       port1_tx_flag_in,
  input  wire logic       port1_rx_flag_in,
  input  wire logic       ale_req_in,
  input  wire logic       ext_access_in,
  input  wire logic       external_data_move_in,
  input  wire logic       wait_pin_in,
  output logic            machine_cycle_out,
  output logic      [1:0] clock_divide_out,
  output logic            crystal_run_out,
  output logic            crystal_select_out,
  output logic            ale_out,
  output logic            xdata_sram_en_out,
  output logic            wait_out,
  output logic            irq_out
);
  logic [7:0] mem_map_q;
  logic [7:0] pmr_q;
  logic [7:0] pmr_d;
  logic [2:0] insvc_q;
  logic [2:0] insvc_d;
  logic [3:0] act_q;
  logic [3:0] act_d;
  logic       crystal_warm_status_q;
  logic [10:0] warm_q;
  logic [10:0] div_cnt_q;
  logic [1:0] ta_cnt_q;
  logic       rx_pend_q;
  logic [`EVT_W-1:0] evt_q;
  logic [`EVT_W-1:0] evt_d;
  logic [`EVT_W-1:0] mask_q;
  clock_divide_power_control_pkg::ta_state_t ta_q;
  clock_divide_power_control_pkg::ta_state_t ta_d;

  default clocking cb @(posedge mclk_in);
  endclocking
  default disable iff (!arst_n_in);

  // address decode
  wire wr_mem  = wr_in && (addr_in == `MEM_MAP_OFS);
  wire wr_pmr  = wr_in && (addr_in == `PWR_MGMT_OFS);
  wire wr_ta   = wr_in && (addr_in == `TA_KEY_OFS);
  wire wr_evt  = wr_in && (addr_in == `EVT_STATUS_OFS);
  wire wr_mask = wr_in && (addr_in == `EVT_MASK_OFS);
  wire [1:0] cdiv = pmr_q[`CDIV_HI_BIT:`CDIV_LO_BIT];
  wire [1:0] cdiv_w = wdata_in[`CDIV_HI_BIT:`CDIV_LO_BIT];
  wire switchback_enable = pmr_q[`SWB_BIT];
  wire ta_open = (ta_q == clock_divide_power_control_pkg::TA_OPEN);
  wire act_busy = |act_q;
  wire div_lock = switchback_enable && act_busy; // R16
  wire rx_start = port0_rx_start_in || port1_rx_start_in;
  wire force_by_int = switchback_enable && ext_int_vector_in; // R3
  wire force_by_rx = switchback_enable && rx_pend_q && instr_start_in; // R4
  wire force_div4 = force_by_int || force_by_rx;

  // machine cycle divider
  wire [10:0] period = (cdiv == `CDIV_DIV64) ? `PER_DIV64 :
                       (cdiv == `CDIV_DIV1024) ? `PER_DIV1024 : `PER_DIV4; // R1
  wire mc_tick = (div_cnt_q == period - 11'h001);
  wire div_change = (pmr_d[`CDIV_HI_BIT:`CDIV_LO_BIT] != cdiv);
  wire [10:0] div_cnt_d = (mc_tick || div_change) ? 11'h000 : div_cnt_q + 11'h001;

  // power management write with its guards
  wire xdis_ok = !pmr_q[`XSEL_BIT] || !wdata_in[`XDIS_BIT]; // R5
  wire xsel_ok = crystal_warm_status_q || !wdata_in[`XSEL_BIT]; // R8
  wire cdiv_ok = !div_lock && (cdiv_w != `CDIV_RSVD);
  always_comb begin
    pmr_d = pmr_q;
    if (wr_pmr) begin
      pmr_d[`SWB_BIT] = wdata_in[`SWB_BIT];
      pmr_d[`ALE_SUP_BIT] = wdata_in[`ALE_SUP_BIT];
      pmr_d[`XDATA_EN_BIT] = wdata_in[`XDATA_EN_BIT];
      if (xdis_ok) begin
        pmr_d[`XDIS_BIT] = wdata_in[`XDIS_BIT]; // R5
      end
      if (xsel_ok) begin
        pmr_d[`XSEL_BIT] = wdata_in[`XSEL_BIT]; // R8
      end
      if (cdiv_ok) begin
        pmr_d[`CDIV_HI_BIT:`CDIV_LO_BIT] = cdiv_w; // R16
      end
    end
    if (force_div4) begin
      pmr_d[`CDIV_HI_BIT:`CDIV_LO_BIT] = `CDIV_DIV4; // R3
    end
  end

  // crystal warm-up and status
  wire xdis_rise = pmr_d[`XDIS_BIT] && !pmr_q[`XDIS_BIT];
  wire xtal_restart = (!pmr_d[`XDIS_BIT] && pmr_q[`XDIS_BIT]) || pd_exit_in;
  wire warm_done = !pmr_q[`XDIS_BIT] && !crystal_warm_status_q && (warm_q == `WARM_CYCLES);
  wire [10:0] warm_d = (xtal_restart || pmr_q[`XDIS_BIT] || crystal_warm_status_q) ? 11'h000 :
                       (warm_q == `WARM_CYCLES) ? warm_q : warm_q + 11'h001;
  wire crystal_warm_status_d = (xdis_rise || xtal_restart) ? 1'b0 : (warm_done ? 1'b1 : crystal_warm_status_q); // R7

  // serial activity: hardware set wins over the flag clear
  wire [3:0] act_set = {port1_tx_start_in, port1_rx_start_in,
                        port0_tx_start_in, port0_rx_start_in};
  wire [3:0] act_clr = {port1_tx_flag_in, port1_rx_flag_in,
                        port0_tx_flag_in, port0_rx_flag_in};
  assign act_d = act_set | (act_q & ~act_clr); // R13 R14 R15

  // in-service: return clears the highest level being serviced
  wire [2:0] insvc_set = {pf_enter_in, hi_enter_in, lo_enter_in};
  wire [2:0] ret_clr = !interrupt_return_in ? 3'h0 :
                       insvc_q[2] ? 3'h4 : insvc_q[1] ? 3'h2 : insvc_q[0] ? 3'h1 : 3'h0;
  assign insvc_d = insvc_set | (insvc_q & ~ret_clr); // R12

  // timed access sequencer
  always_comb begin
    ta_d = ta_q;
    case (ta_q)
      clock_divide_power_control_pkg::TA_IDLE: begin
        if (wr_ta && wdata_in == `TA_KEY_FIRST) begin
          ta_d = clock_divide_power_control_pkg::TA_HALF; // R17
        end
      end
      clock_divide_power_control_pkg::TA_HALF: begin
        if (wr_ta && wdata_in == `TA_KEY_SECOND) begin
          ta_d = clock_divide_power_control_pkg::TA_OPEN; // R17
        end else if (wr_in) begin
          ta_d = clock_divide_power_control_pkg::TA_IDLE; // R18
        end
      end
      clock_divide_power_control_pkg::TA_OPEN: begin
        if (mc_tick && ta_cnt_q == `TA_OPEN_MC - 2'h1) begin
          ta_d = clock_divide_power_control_pkg::TA_IDLE; // R19
        end
      end
      default: ta_d = clock_divide_power_control_pkg::TA_IDLE;
    endcase
  end
  wire [1:0] ta_cnt_d = !ta_open ? 2'h0 : (mc_tick ? ta_cnt_q + 2'h1 : ta_cnt_q);
  wire [7:0] mem_map_d = (wr_mem && ta_open) ? (wdata_in & 8'h80) : mem_map_q; // R18

  // events and interrupt
  wire [`EVT_W-1:0] evt_set = {warm_done, force_div4};
  wire [`EVT_W-1:0] evt_clr = wr_evt ? wdata_in[`EVT_W-1:0] : {`EVT_W{1'b0}};
  assign evt_d = evt_set | (evt_q & ~evt_clr);

  // read mux
  wire [7:0] status_rd = {insvc_q, crystal_warm_status_q, act_q};
  wire [7:0] rd_mux = (addr_in == `MEM_MAP_OFS) ? mem_map_q :
                      (addr_in == `PWR_MGMT_OFS) ? pmr_q :
                      (addr_in == `ACT_STATUS_OFS) ? status_rd :
                      (addr_in == `EVT_STATUS_OFS) ? {6'h00, evt_q} :
                      (addr_in == `EVT_MASK_OFS) ? {6'h00, mask_q} : 8'h00;

  // pin side
  wire ale_d = ale_req_in && (ext_access_in || !pmr_q[`ALE_SUP_BIT]); // R9
  wire wait_d = mem_map_q[`WAIT_EN_BIT] && external_data_move_in && wait_pin_in; // R11
  wire sram_d = pmr_q[`XDATA_EN_BIT] && external_data_move_in; // R10

  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      pmr_q <= {`CDIV_RST, 6'h00};
      mem_map_q <= 8'h00;
      div_cnt_q <= 11'h000;
      ta_q <= clock_divide_power_control_pkg::TA_IDLE;
      ta_cnt_q <= 2'h0;
    end else begin
      pmr_q <= pmr_d;
      mem_map_q <= mem_map_d;
      div_cnt_q <= div_cnt_d;
      ta_q <= ta_d;
      ta_cnt_q <= ta_cnt_d;
    end
  end

  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      crystal_warm_status_q <= `CRYSTAL_WARM_STATUS_RST;
      warm_q <= 11'h000;
      act_q <= 4'h0;
      insvc_q <= 3'h0;
      rx_pend_q <= 1'b0;
    end else begin
      crystal_warm_status_q <= crystal_warm_status_d; // R6
      warm_q <= warm_d;
      act_q <= act_d;
      insvc_q <= insvc_d;
      rx_pend_q <= rx_start || (rx_pend_q && !instr_start_in); // R4
    end
  end

  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      evt_q <= {`EVT_W{1'b0}};
      mask_q <= {`EVT_W{1'b0}};
      irq_out <= 1'b0;
      rdata_out <= 8'h00;
    end else begin
      evt_q <= evt_d;
      mask_q <= wr_mask ? wdata_in[`EVT_W-1:0] : mask_q;
      irq_out <= |(evt_d & mask_q);
      rdata_out <= rd_in ? rd_mux : 8'h00;
    end
  end

  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      machine_cycle_out <= 1'b0;
      clock_divide_out <= `CDIV_RST;
      crystal_run_out <= 1'b1;
      crystal_select_out <= 1'b0;
      ale_out <= 1'b0;
      xdata_sram_en_out <= 1'b0;
      wait_out <= 1'b0;
    end else begin
      machine_cycle_out <= mc_tick; // R1
      clock_divide_out <= pmr_d[`CDIV_HI_BIT:`CDIV_LO_BIT];
      crystal_run_out <= !pmr_d[`XDIS_BIT]; // R5 R6
      crystal_select_out <= pmr_d[`XSEL_BIT];
      ale_out <= ale_d;
      xdata_sram_en_out <= sram_d;
      wait_out <= wait_d;
    end
  end

  // checks

  a_div4_period: assert property ( // R1
    (mc_tick && cdiv == `CDIV_DIV4 && !div_change) ##1 (cdiv == `CDIV_DIV4)[*4]
    |-> mc_tick)
    else $error("divide by 4 tick spacing wrong");
  a_int_switchback: assert property ( // R3
    (switchback_enable && ext_int_vector_in) |=> clock_divide_out == `CDIV_DIV4)
    else $error("interrupt switchback missed");
  a_rx_switchback: assert property ( // R4
    (switchback_enable && rx_pend_q && instr_start_in) |=> cdiv == `CDIV_DIV4)
    else $error("reception switchback missed");
  a_xdis_guard: assert property ( // R5
    (wr_pmr && pmr_q[`XSEL_BIT] && !pmr_q[`XDIS_BIT]) |=> !pmr_q[`XDIS_BIT])
    else $error("crystal disabled while on crystal");
  a_crystal_warm_status_clear: assert property ( // R7
    (!pmr_q[`XDIS_BIT] && pmr_d[`XDIS_BIT]) |=> !crystal_warm_status_q)
    else $error("warm status not cleared on disable");
  a_xsel_block: assert property ( // R8
    (!crystal_warm_status_q && !pmr_q[`XSEL_BIT]) |=> !pmr_q[`XSEL_BIT])
    else $error("crystal select set before warm-up");
  a_ale_suppress: assert property ( // R9
    (pmr_q[`ALE_SUP_BIT] && !ext_access_in) |=> !ale_out)
    else $error("strobe shown on on-chip access");
  a_act_set: assert property ( // R15
    port0_rx_start_in |=> act_q[0])
    else $error("activity bit not set");
  a_div_lock: assert property ( // R16
    (div_lock && !force_div4) |=> $stable(cdiv))
    else $error("divide changed while locked");
  a_ta_protect: assert property ( // R18
    !ta_open |=> $stable(mem_map_q))
    else $error("protected bit changed while locked");
  a_ta_close: assert property ( // R19
    (ta_open && mc_tick && ta_cnt_q == 2'h2) |=> !ta_open)
    else $error("window stayed open");
  a_interrupt_return_clear: assert property ( // R12
    (interrupt_return_in && insvc_q[2] && !pf_enter_in) |=> !insvc_q[2])
    else $error("return did not clear in-service");

  // divider and switchback checks
  a_no_reserved: assert property ( // R1
    cdiv != `CDIV_RSVD)
    else $error("reserved divide code loaded");
  a_count_range: assert property ( // R1
    div_cnt_q < period)
    else $error("divider count beyond period");
  a_tick_spacing: assert property ( // R1
    mc_tick |=> !mc_tick)
    else $error("machine cycle ticks too close");
  a_tick_output: assert property ( // R1
    mc_tick |=> machine_cycle_out)
    else $error("machine cycle pulse not shown");
  a_int_event: assert property ( // R3
    (switchback_enable && ext_int_vector_in) |=> evt_q[`EVT_SWB_BIT])
    else $error("switchback event not recorded");
  a_rx_pending: assert property ( // R4
    rx_start |=> rx_pend_q)
    else $error("reception start not held pending");

  // crystal checks
  a_xdis_accept: assert property ( // R5
    (wr_pmr && !pmr_q[`XSEL_BIT] && wdata_in[`XDIS_BIT]) |=> pmr_q[`XDIS_BIT])
    else $error("crystal disable refused on RC clock");
  a_crystal_output: assert property ( // R5
    crystal_run_out == !pmr_q[`XDIS_BIT])
    else $error("crystal run output disagrees with disable");
  a_warm_set: assert property ( // R6
    (warm_done && !pd_exit_in && !pmr_d[`XDIS_BIT]) |=> crystal_warm_status_q)
    else $error("warm status not set after warm-up");
  a_pdexit_clear: assert property ( // R7
    pd_exit_in |=> !crystal_warm_status_q)
    else $error("warm status kept over power-down exit");

  // pin side checks
  a_ale_external: assert property ( // R9
    (ale_req_in && ext_access_in) |=> ale_out)
    else $error("strobe missing on external access");
  a_sram_gate: assert property ( // R10
    !pmr_q[`XDATA_EN_BIT] |=> !xdata_sram_en_out)
    else $error("on-chip sram enabled while off");
  a_sram_enable: assert property ( // R10
    (pmr_q[`XDATA_EN_BIT] && external_data_move_in) |=> xdata_sram_en_out)
    else $error("on-chip sram not enabled for data move");
  a_wait_gate: assert property ( // R11
    !mem_map_q[`WAIT_EN_BIT] |=> !wait_out)
    else $error("wait passed while disabled");
  a_wait_sample: assert property ( // R11
    (mem_map_q[`WAIT_EN_BIT] && external_data_move_in && wait_pin_in) |=> wait_out)
    else $error("wait not passed during data move");

  // status and timed access checks
  a_insvc_set: assert property ( // R12
    pf_enter_in |=> insvc_q[2])
    else $error("power-fail in-service not set");
  a_p1tx_clear: assert property ( // R13
    (port1_tx_flag_in && !port1_tx_start_in) |=> !act_q[3])
    else $error("port 1 transmit activity not cleared");
  a_p1rx_clear: assert property ( // R14
    (port1_rx_flag_in && !port1_rx_start_in) |=> !act_q[2])
    else $error("port 1 receive activity not cleared");
  a_p0tx_clear: assert property ( // R15
    (port0_tx_flag_in && !port0_tx_start_in) |=> !act_q[1])
    else $error("port 0 transmit activity not cleared");
  a_ta_unlock: assert property ( // R17
    (ta_q == clock_divide_power_control_pkg::TA_HALF && wr_ta && wdata_in == `TA_KEY_SECOND)
    |=> ta_open)
    else $error("window did not open after key pair");
  a_ta_abort: assert property ( // R18
    (ta_q == clock_divide_power_control_pkg::TA_HALF && wr_in && !wr_ta)
    |=> ta_q == clock_divide_power_control_pkg::TA_IDLE)
    else $error("unlock not aborted by other write");
  a_irq_level: assert property ( // R3 R6
    (|(evt_q & mask_q) && !wr_mask && !wr_evt) |=> irq_out)
    else $error("interrupt output low with pending event");

  c_unlock: cover property (ta_open ##1 wr_mem);
  c_switchback: cover property (force_by_rx);
  c_warm: cover property (warm_done);
  c_slow: cover property (cdiv == `CDIV_DIV1024 && mc_tick);
  c_abort: cover property (ta_q == clock_divide_power_control_pkg::TA_HALF && wr_pmr);
endmodule

// ---- bench/testbench.sv ----
// self-checking bench for the clock divide and power control block
`timescale 1ns/1ps
`include "clock_divide_power_control_regs.svh"
module testbench;
  logic        mclk_in, arst_n_in, wr_in, rd_in;
  logic [7:0]  addr_in, wdata_in, rv;
  wire  [7:0]  rdata_out;
  logic [14:0] ev;
  logic        ale_req, ext_acc, xdm, wait_pin;
  logic [10:0] n;
  wire         mc, xrun, xsel, ale, sram, waitq, irq;
  wire  [1:0]  cdiv;
  int          failures, checks, cycles, i, b;
  logic [23:0] rows [10] = '{24'hC48080, 24'hC44040, 24'hC4C0C0, 24'hC400C0, 24'hC44040,
                             24'hC28000, 24'h10FF00, 24'hC71200, 24'hC5FF10, 24'hC44545};
  logic [1:0]  codes [4] = '{2'h2, 2'h1, 2'h3, 2'h1};
  int          st [4] = '{8, 7, 12, 11};
  int          fl [4] = '{10, 9, 14, 13};
  logic [7:0]  isv [3] = '{8'h70, 8'h30, 8'h10};

  clock_divide_power_control i_clock_divide_power_control (
    .mclk_in(mclk_in), .arst_n_in(arst_n_in), .addr_in(addr_in), .wdata_in(wdata_in),
    .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .ext_int_vector_in(ev[0]),
    .instr_start_in(ev[1]), .pd_exit_in(ev[2]), .pf_enter_in(ev[3]), .hi_enter_in(ev[4]),
    .lo_enter_in(ev[5]), .interrupt_return_in(ev[6]), .port0_tx_start_in(ev[7]),
    .port0_rx_start_in(ev[8]), .port0_tx_flag_in(ev[9]), .port0_rx_flag_in(ev[10]),
    .port1_tx_start_in(ev[11]), .port1_rx_start_in(ev[12]), .port1_tx_flag_in(ev[13]),
    .port1_rx_flag_in(ev[14]), .ale_req_in(ale_req), .ext_access_in(ext_acc),
    .external_data_move_in(xdm), .wait_pin_in(wait_pin), .machine_cycle_out(mc),
    .clock_divide_out(cdiv), .crystal_run_out(xrun), .crystal_select_out(xsel),
    .ale_out(ale), .xdata_sram_en_out(sram), .wait_out(waitq), .irq_out(irq));

  initial begin
    mclk_in = 1'b0;
    forever #2.5 mclk_in = ~mclk_in;
  end

  task chk(input string nm, input logic [10:0] seen, input logic [10:0] exp);
    checks++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk_in);
    wr_in <= 1'b1;
    addr_in <= a;
    wdata_in <= d;
    @(posedge mclk_in);
    wr_in <= 1'b0;
  endtask

  task rd(input logic [7:0] a);
    @(posedge mclk_in);
    rd_in <= 1'b1;
    addr_in <= a;
    @(posedge mclk_in);
    rd_in <= 1'b0;
    #1 rv = rdata_out;
  endtask

  task pulse(input int k);
    @(posedge mclk_in);
    ev[k] <= 1'b1;
    @(posedge mclk_in);
    ev <= 15'h0000;
  endtask

  task do_reset;
    arst_n_in <= 1'b0;
    repeat (10) @(posedge mclk_in);
    arst_n_in <= 1'b1;
    #1 chk("cdiv_rst", cdiv, `CDIV_RST);
    chk("xrun_rst", xrun, 1'b1);
    rd(`PWR_MGMT_OFS);
    chk("pmr_rst", rv, 8'h40);
    rd(`ACT_STATUS_OFS);
    chk("status_rst", rv, 8'h10);
    rd(`MEM_MAP_OFS);
    chk("map_rst", rv, 8'h00);
  endtask

  task wrap_up;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  always @(posedge mclk_in) begin
    cycles++;
    if (cycles == 30000) begin
      failures++;
      wrap_up();
    end
  end

  initial begin
    {wr_in, rd_in, addr_in, wdata_in, ev} = '0;
    {ale_req, ext_acc, xdm, wait_pin} = '0;
    arst_n_in = 1'b0;
    do_reset();
    for (i = 0; i < 10; i++) begin
      wr(rows[i][23:16], rows[i][15:8]);
      rd(rows[i][23:16]);
      chk("row_read", rv, rows[i][7:0]);
      if (rows[i][23:16] == `PWR_MGMT_OFS) chk("row_cdiv", cdiv, rows[i][7:6]);
    end
    // slow settings are only entered from divide-by-4
    for (i = 0; i < 4; i++) begin
      wr(`PWR_MGMT_OFS, {codes[i], 6'h05});
      @(posedge mclk_in);
      #1 while (mc !== 1'b1 && cycles < 29000) @(posedge mclk_in) #1;
      n = 0;
      do begin
        @(posedge mclk_in);
        #1 n++;
      end while (mc !== 1'b1 && n < 11'h7FF);
      chk("mc_period", n, codes[i] == 2'h1 ? `PER_DIV4 : codes[i] == 2'h2 ?
          `PER_DIV64 : `PER_DIV1024);
    end
    @(posedge mclk_in);
    ale_req <= 1'b1;
    xdm <= 1'b1;
    wait_pin <= 1'b1;
    repeat (3) @(posedge mclk_in);
    #1 chk("ale_onchip", ale, 1'b0);
    chk("sram_en", sram, 1'b1);
    chk("wait_locked", waitq, 1'b0);
    @(posedge mclk_in);
    ext_acc <= 1'b1;
    repeat (3) @(posedge mclk_in);
    #1 chk("ale_ext", ale, 1'b1);
    wr(`TA_KEY_OFS, `TA_KEY_FIRST);
    wr(`TA_KEY_OFS, `TA_KEY_SECOND);
    wr(`MEM_MAP_OFS, 8'h80);
    repeat (3) @(posedge mclk_in);
    #1 chk("wait_on", waitq, 1'b1);
    repeat (20) @(posedge mclk_in);
    wr(`TA_KEY_OFS, `TA_KEY_FIRST);
    wr(`PWR_MGMT_OFS, 8'h45);
    wr(`TA_KEY_OFS, `TA_KEY_SECOND);
    wr(`MEM_MAP_OFS, 8'h00);
    rd(`MEM_MAP_OFS);
    chk("ta_abort", rv, 8'h80);
    wr(`TA_KEY_OFS, `TA_KEY_FIRST);
    wr(`TA_KEY_OFS, `TA_KEY_SECOND);
    repeat (20) @(posedge mclk_in);
    wr(`MEM_MAP_OFS, 8'h00);
    rd(`MEM_MAP_OFS);
    chk("ta_closed", rv, 8'h80);
    wr(`PWR_MGMT_OFS, 8'h65);
    for (b = 0; b < 4; b++) begin
      pulse(st[b]);
      rd(`ACT_STATUS_OFS);
      chk("act_set", rv, 8'h10 | (8'h01 << b));
      wr(`PWR_MGMT_OFS, 8'hA5);
      rd(`PWR_MGMT_OFS);
      chk("div_locked", rv, 8'h65);
      pulse(fl[b]);
      rd(`ACT_STATUS_OFS);
      chk("act_clr", rv, 8'h10);
    end
    pulse(1);
    wr(`EVT_STATUS_OFS, 8'h01);
    rd(`EVT_STATUS_OFS);
    chk("evt_idle", rv, 8'h00);
    wr(`PWR_MGMT_OFS, 8'hE5);
    wr(`EVT_MASK_OFS, 8'h01);
    pulse(0);
    rd(`PWR_MGMT_OFS);
    chk("swb_int", rv, 8'h65);
    chk("irq_swb", irq, 1'b1);
    wr(`EVT_STATUS_OFS, 8'h01);
    repeat (2) @(posedge mclk_in);
    #1 chk("irq_clr", irq, 1'b0);
    wr(`PWR_MGMT_OFS, 8'hE5);
    pulse(12);
    #1 chk("swb_wait", cdiv, `CDIV_DIV1024);
    pulse(1);
    rd(`PWR_MGMT_OFS);
    chk("swb_rx", rv, 8'h65);
    pulse(14);
    pulse(3);
    pulse(4);
    pulse(5);
    rd(`ACT_STATUS_OFS);
    chk("isv_set", rv, 8'hF0);
    for (i = 0; i < 3; i++) begin
      pulse(6);
      rd(`ACT_STATUS_OFS);
      chk("isv_ret", rv, isv[i]);
    end
    wr(`PWR_MGMT_OFS, 8'h6D);
    #1 chk("xsel_on", xsel, 1'b1);
    wr(`PWR_MGMT_OFS, 8'h6F);
    rd(`PWR_MGMT_OFS);
    chk("xdis_refused", rv, 8'h6D);
    wr(`PWR_MGMT_OFS, 8'h65);
    wr(`PWR_MGMT_OFS, 8'h67);
    wr(`PWR_MGMT_OFS, 8'h6F);
    rd(`PWR_MGMT_OFS);
    chk("xsel_refused", rv, 8'h67);
    chk("xsel_off", xsel, 1'b0);
    chk("xrun_off", xrun, 1'b0);
    rd(`ACT_STATUS_OFS);
    chk("warm_clr", rv, 8'h00);
    wr(`EVT_MASK_OFS, 8'h02);
    wr(`PWR_MGMT_OFS, 8'h65);
    repeat (500) @(posedge mclk_in);
    rd(`ACT_STATUS_OFS);
    chk("warm_early", rv, 8'h00);
    repeat (600) @(posedge mclk_in);
    rd(`ACT_STATUS_OFS);
    chk("warm_done", rv, 8'h10);
    chk("xrun_on", xrun, 1'b1);
    chk("irq_warm", irq, 1'b1);
    pulse(2);
    rd(`ACT_STATUS_OFS);
    chk("warm_pdexit", rv, 8'h00);
    do_reset();
    wrap_up();
  end
endmodule
